// ===== bench/csm_osc_model.sv
// Oscillator, crystal start-up and PLL model facing the clock switch
`timescale 1ns/1ps
`default_nettype none
module csm_osc_model (
    input wire logic [4:0] osc_enable,
    input wire logic fail,
    output logic new_src_clk,
    output logic sys_src_clk,
    output logic low_power_rc_oscillator_clk,
    output logic startup_timer_done,
    output logic pll_lock
);
    int xtal_ns = 0;
    int pll_ns = 0;
    initial begin
        {new_src_clk, sys_src_clk, low_power_rc_oscillator_clk, startup_timer_done, pll_lock} = 5'h00;
    end
    // New clock stands still while every oscillator is off
    always #110 new_src_clk = (|osc_enable) ? ~new_src_clk : 1'b0;
    // A failed source stops toggling
    always #90 sys_src_clk = fail ? sys_src_clk : ~sys_src_clk;
    // Reference runs only while enabled
    always #170 low_power_rc_oscillator_clk = osc_enable[3] ? ~low_power_rc_oscillator_clk : 1'b0;
    // Slow crystal start-up and PLL lock
    // Start-up and lock restart from zero whenever their oscillator is off
    always #10 begin
        xtal_ns = (|osc_enable[1:0]) ? xtal_ns + 10 : 0;
        pll_ns = osc_enable[4] ? pll_ns + 10 : 0;
        startup_timer_done = (xtal_ns >= 1500);
        pll_lock = (pll_ns >= 800);
    end
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the clock switch and fail-safe monitor
`timescale 1ns/1ps
`default_nettype none
module tb
    import csm_pkg::*;
;
    logic clk, rstn, fail;
    csm_bus_t bus;
    csm_cfg_t cfg;
    logic [15:0] rd_data, d;
    logic [2:0] sys_clk_select, sw_tgt;
    logic [4:0] osc_enable;
    logic [5:0] tuning_step_field;
    logic new_src_clk, sys_src_clk, low_power_rc_oscillator_clk, startup_timer_done, pll_lock, clock_fail_trap;
    int n_fail = 0;
    int total_checks = 0;
    int cur, t;

    csm_clock_switch u_dut (.clk(clk), .rstn(rstn), .bus(bus), .rd_data(rd_data), .cfg(cfg),
        .new_src_clk(new_src_clk), .sys_src_clk(sys_src_clk), .low_power_rc_oscillator_clk(low_power_rc_oscillator_clk),
        .startup_timer_done(startup_timer_done), .pll_lock(pll_lock),
        .sys_clk_select(sys_clk_select), .switch_target(sw_tgt), .osc_enable(osc_enable),
        .tuning_step_field(tuning_step_field), .clock_fail_trap(clock_fail_trap));
    csm_osc_model u_osc (.osc_enable(osc_enable), .fail(fail), .new_src_clk(new_src_clk),
        .sys_src_clk(sys_src_clk), .low_power_rc_oscillator_clk(low_power_rc_oscillator_clk),
        .startup_timer_done(startup_timer_done), .pll_lock(pll_lock));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic stop_test();
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic cw(input logic [3:0] a, input logic [15:0] v);
        wr(CSM_ADDR_KEY, CSM_KEY1);
        wr(CSM_ADDR_KEY, CSM_KEY2);
        wr(a, v);
    endtask

    task automatic request(input int n, input int keep);
        cw(CSM_ADDR_CTRL_HI, 16'(n << CSM_REQ_LSB));
        cw(CSM_ADDR_CTRL_LO, 16'(keep * 2 + 1));
    endtask

    function automatic logic [4:0] osc_of(input int s);
        case (s)
            0: return 5'h04;
            1: return 5'h14;
            2: return 5'h01;
            3: return 5'h11;
            4: return 5'h02;
            default: return 5'h08;
        endcase
    endfunction

    task automatic wait_sys(input int n);
        for (int i = 0; i < 1000 && sys_clk_select !== 3'(n); i++) begin
            @(posedge clk);
            #1;
        end
        if (sys_clk_select !== 3'(n)) begin
            n_fail++;
            stop_test();
        end
    endtask

    task automatic switch_to(input int n, input int keep);
        request(n, keep);
        repeat (20) @(posedge clk);
        #1 chk(16'(sys_clk_select), 16'(cur));
        chk(16'(sw_tgt), 16'(n));
        wait_sys(n);
        cur = n;
        repeat (2) @(posedge clk);
        rd(CSM_ADDR_CTRL_LO);
        chk(d & 16'h770b, 16'((n << 12) | (n << 8) | keep * 2));
        chk(16'(osc_enable), 16'(osc_of(n) | 5'h08 | (keep != 0 ? 5'h02 : 5'h00)));
    endtask

    task automatic fail_at(input int fb);
        fail = 1'b1;
        for (int i = 0; i < 400 && clock_fail_trap !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk(16'(clock_fail_trap), 16'h0001);
        fail = 1'b0;
        wait_sys(fb);
        cur = fb;
        rd(CSM_ADDR_CTRL_LO);
        chk(d & 16'h7008, 16'((fb << 12) | 8));
        chk(16'(osc_enable[3]), 16'h0001);
    endtask

    initial begin
        rstn = 1'b0;
        fail = 1'b0;
        bus = '0;
        cfg = '{1'b0, 3'h0, 2'h1, 1'b0};
        cur = 0;
        void'($urandom(32'h26f7));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(16'(sys_clk_select), 16'h0000);
        chk(16'(osc_enable), 16'h000c);
        rd(CSM_ADDR_TUNE);
        chk(d, CSM_TUNE_RESET);
        for (int i = 0; i < 6; i++) begin
            t = (i == 0) ? 32'h0000_0001 : (i == 1) ? 32'h0000_003f : int'($urandom);
            wr(CSM_ADDR_TUNE, 16'(t));
            rd(CSM_ADDR_TUNE);
            chk(d, 16'(t) & 16'h003f);
            chk(16'(tuning_step_field), 16'(t) & 16'h003f);
        end
        wr(CSM_ADDR_CTRL_HI, 16'h0200);
        wr(CSM_ADDR_KEY, CSM_KEY1);
        wr(CSM_ADDR_CTRL_HI, 16'h0300);
        rd(CSM_ADDR_CTRL_HI);
        chk(d & 16'h0700, 16'h0000);
        request(0, 0);
        repeat (10) @(posedge clk);
        rd(CSM_ADDR_CTRL_LO);
        chk(d & 16'h7701, 16'h0000);
        // Every requested switch avoids a direct hop between the two multiplied modes
        switch_to(2, 0);
        switch_to(3, 0);
        switch_to(0, 0);
        switch_to(4, 0);
        switch_to(5, 1);
        switch_to(0, 0);
        switch_to(1, 0);
        switch_to(0, 0);
        switch_to(2, 0);
        fail_at(0);
        switch_to(3, 0);
        fail_at(1);
        @(posedge clk);
        rstn <= 1'b0;
        cfg <= '{1'b1, 3'h2, 2'h0, 1'b1};
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(16'(sys_clk_select), 16'h0002);
        request(0, 0);
        repeat (300) @(posedge clk);
        #1 chk(16'(sys_clk_select), 16'h0002);
        rd(CSM_ADDR_CTRL_LO);
        chk(d & 16'h7001, 16'h2000);
        fail = 1'b1;
        t = 0;
        repeat (300) begin
            @(posedge clk);
            #1 t += (clock_fail_trap !== 1'b0) ? 1 : 0;
        end
        chk(16'(t), 16'h0000);
        chk(16'(osc_enable[3]), 16'h0001);
        stop_test();
    end
endmodule
`default_nettype wire

// ===== verilog/csm_clock_switch.sv
// Clock source switch controller with fail-safe monitor and fast RC tuning
//
// Behaviour
// - Software selects any of six sources; an unlock guards the switch.
// - Primary submode comes from configuration only, never from software.
// - Switching and fail-safe monitor work only when switching config is 0.
// - Switching disabled: requested source ignored, current source follows config.
// - Switching disabled: switch-request bit ignored and held at 0.
// - Request equal to current source clears request bit and aborts.
// - Valid switch start clears lock status and clock-fail status.
// - Start new oscillator, wait start-up timer for crystals, PLL lock if used.
// - Wait 10 new-clock cycles before moving the system clock.
// - Completion clears request bit and copies requested into current source.
// - Old source turned off; low-power RC and crystal keep-on exceptions.
// - Processor keeps running during the switch; block never stalls software.
// - Fail-safe enabled keeps the low-power RC running always.
// - Oscillator failure raises a trap and falls back to fast RC.
// - Failure with PLL in use falls back to fast RC through the PLL.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module csm_clock_switch
    import csm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire csm_bus_t bus,
    output logic [15:0] rd_data,
    input wire csm_cfg_t cfg,
    input wire logic new_src_clk,
    input wire logic sys_src_clk,
    input wire logic low_power_rc_oscillator_clk,
    input wire logic startup_timer_done,
    input wire logic pll_lock,
    output logic [2:0] sys_clk_select,
    output logic [2:0] switch_target,
    output logic [4:0] osc_enable,
    output logic [5:0] tuning_step_field,
    output logic clock_fail_trap
);
    typedef struct packed {
        csm_state_t st;
        logic cfg_done;
        csm_cfg_t cfg;
        csm_src_t cur;
        csm_src_t req_src;
        logic req;
        logic lock;
        logic cf;
        logic keep_lp;
        logic [5:0] tune;
        logic [1:0] key;
        logic [3:0] settle;
        logic [3:0] fail_cnt;
        logic trap;
        logic [15:0] rdata;
        logic [4:0] osc_en;
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [2:0] prev;
    } csm_q_t;

    csm_q_t q;
    csm_q_t d;
    logic new_e;
    logic mon_e;
    logic ref_e;
    logic sw_en;
    logic ctrl_ok;

    function automatic logic [4:0] src_osc(input csm_src_t s);
        logic [4:0] v;
        v = 5'h00;
        case (s)
            CSM_SRC_FRC: v[CSM_OSC_FRC] = 1'b1;
            CSM_SRC_FRC_PLL: v = 5'h14;
            CSM_SRC_PRI: v[CSM_OSC_PRI] = 1'b1;
            CSM_SRC_PRI_PLL: v = 5'h11;
            CSM_SRC_LP: v[CSM_OSC_LP] = 1'b1;
            CSM_SRC_LOW_POWER_RC_OSCILLATOR: v[CSM_OSC_LOW_POWER_RC_OSCILLATOR] = 1'b1;
            default: v = 5'h00;
        endcase
        return v;
    endfunction

    function automatic logic uses_pll(input csm_src_t s);
        return (s == CSM_SRC_FRC_PLL) || (s == CSM_SRC_PRI_PLL);
    endfunction

    assign new_e = q.sync2[CSM_IN_NEW] & ~q.prev[CSM_IN_NEW];
    assign mon_e = q.sync2[CSM_IN_MON] & ~q.prev[CSM_IN_MON];
    assign ref_e = q.sync2[CSM_IN_REF] & ~q.prev[CSM_IN_REF];
    assign sw_en = q.cfg_done & ~q.cfg.switching_enable_config;
    assign ctrl_ok = bus.wr && (q.key == CSM_KEY_OPEN);

    always_comb begin
        d = q;
        d.sync1 = {pll_lock, startup_timer_done, low_power_rc_oscillator_clk, sys_src_clk, new_src_clk};
        d.sync2 = q.sync1;
        d.prev = q.sync2[2:0];
        d.trap = 1'b0;
        d.rdata = 16'h0000;
        // Configuration straps caught once after reset release
        if (!q.cfg_done) begin
            d.cfg_done = 1'b1;
            d.cfg = cfg;
            d.cur = csm_src_t'(cfg.initial_source_config);
            d.req_src = csm_src_t'(cfg.initial_source_config);
        end
        if (q.sync2[CSM_IN_PLL]) begin
            d.lock = 1'b1;
        end
        // unlock sequence, any write consumes it
        if (bus.wr) begin
            if (bus.addr == CSM_ADDR_KEY && bus.wdata == CSM_KEY1) begin
                d.key = CSM_KEY_HALF;
            end else if (bus.addr == CSM_ADDR_KEY && bus.wdata == CSM_KEY2
                         && q.key == CSM_KEY_HALF) begin
                d.key = CSM_KEY_OPEN;
            end else begin
                d.key = CSM_KEY_NONE;
            end
        end
        if (ctrl_ok && bus.addr == CSM_ADDR_CTRL_HI && q.st == CSM_IDLE) begin
            d.req_src = csm_src_t'(bus.wdata[CSM_REQ_LSB +: 3]);
        end
        if (ctrl_ok && bus.addr == CSM_ADDR_CTRL_LO) begin
            d.keep_lp = bus.wdata[CSM_KEEP_BIT];
            d.cf = q.cf & bus.wdata[CSM_CF_BIT];
            d.req = q.req | (bus.wdata[CSM_SW_BIT] & sw_en);
        end
        if (bus.wr && bus.addr == CSM_ADDR_TUNE) begin
            d.tune = bus.wdata[5:0];
        end
        if (bus.rd) begin
            case (bus.addr)
                CSM_ADDR_CTRL_HI, CSM_ADDR_CTRL_LO: begin
                    d.rdata[CSM_CUR_LSB +: 3] = q.cur;
                    d.rdata[CSM_REQ_LSB +: 3] = q.req_src;
                    d.rdata[CSM_LOCK_BIT] = q.lock;
                    d.rdata[CSM_CF_BIT] = q.cf;
                    d.rdata[CSM_KEEP_BIT] = q.keep_lp;
                    d.rdata[CSM_SW_BIT] = q.req;
                end
                CSM_ADDR_TUNE: d.rdata[5:0] = q.tune;
                default: d.rdata = 16'h0000;
            endcase
        end
        case (q.st)
            CSM_IDLE: begin
                if (q.cfg_done && !sw_en) begin
                    d.cur = csm_src_t'(q.cfg.initial_source_config);
                    d.req = 1'b0;
                end else if (q.req) begin
                    if (q.req_src == q.cur) begin
                        d.req = 1'b0;
                    end else begin
                        d.lock = 1'b0;
                        d.cf = 1'b0;
                        d.settle = 4'h0;
                        d.st = CSM_WAIT;
                    end
                end
            end
            CSM_WAIT: begin
                // wait for start-up timer and PLL lock; external clock needs no timer
                if ((!((q.req_src == CSM_SRC_LP) || ((q.req_src == CSM_SRC_PRI
                      || q.req_src == CSM_SRC_PRI_PLL)
                      && q.cfg.primary_submode_select != CSM_SUB_EC))
                      || q.sync2[CSM_IN_OST])
                    && (!uses_pll(q.req_src) || q.sync2[CSM_IN_PLL])) begin
                    d.st = CSM_SETTLE;
                end
            end
            CSM_SETTLE: begin
                if (new_e) begin
                    if (q.settle == CSM_SETTLE_EDGES - 4'h1) begin
                        d.cur = q.req_src;
                        d.req = 1'b0;
                        d.st = CSM_IDLE;
                    end else begin
                        d.settle = q.settle + 4'h1;
                    end
                end
            end
            default: d.st = CSM_IDLE;
        endcase
        // reference edges counted between system-source edges
        if (sw_en && !q.cf) begin
            if (mon_e) begin
                d.fail_cnt = 4'h0;
            end else if (ref_e) begin
                if (q.fail_cnt == CSM_FAIL_EDGES - 4'h1) begin
                    // trap and fall back to fast RC
                    d.cf = 1'b1;
                    d.trap = 1'b1;
                    // keep the PLL if it was in use
                    d.cur = uses_pll(q.cur) ? CSM_SRC_FRC_PLL : CSM_SRC_FRC;
                    d.req = 1'b0;
                    d.st = CSM_IDLE;
                    d.fail_cnt = 4'h0;
                end else begin
                    d.fail_cnt = q.fail_cnt + 4'h1;
                end
            end
        end
        // old source off once current moves, keep-on exceptions
        d.osc_en = src_osc(d.cur) | ((d.st != CSM_IDLE) ? src_osc(d.req_src) : 5'h00);
        // low-power RC held on for watchdog or monitor
        if (d.cfg.watchdog_en || (d.cfg_done && !d.cfg.switching_enable_config)) begin
            d.osc_en[CSM_OSC_LOW_POWER_RC_OSCILLATOR] = 1'b1;
        end
        if (d.keep_lp) begin
            d.osc_en[CSM_OSC_LP] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '{st: CSM_IDLE, cfg: '0, cur: CSM_SRC_FRC, req_src: CSM_SRC_FRC,
                   tune: CSM_TUNE_RESET[5:0], default: '0};
        end else begin
            q <= d;
        end
    end

    assign rd_data = q.rdata;
    assign sys_clk_select = q.cur;
    assign switch_target = q.req_src;
    assign osc_enable = q.osc_en;
    assign tuning_step_field = q.tune;
    assign clock_fail_trap = q.trap;

    redundant_abort_a: assert property (@(posedge clk) disable iff (!rstn)
        q.st == CSM_IDLE && sw_en && q.req && q.req_src == q.cur |=> !q.req)
        else $error("redundant request not aborted");
    start_clears_a: assert property (@(posedge clk) disable iff (!rstn)
        q.st == CSM_IDLE && sw_en && q.req && q.req_src != q.cur && !ref_e
        |=> q.st == CSM_WAIT && !q.cf)
        else $error("switch start did not clear status");
    req_held_low_a: assert property (@(posedge clk) disable iff (!rstn)
        q.cfg_done && !sw_en |=> !q.req)
        else $error("request bit set while switching disabled");
    cur_follows_cfg_a: assert property (@(posedge clk) disable iff (!rstn)
        q.cfg_done && !sw_en |=> q.cur == csm_src_t'(q.cfg.initial_source_config))
        else $error("current source differs from configuration");
    pll_wait_a: assert property (@(posedge clk) disable iff (!rstn)
        q.st == CSM_WAIT && uses_pll(q.req_src) && !q.sync2[CSM_IN_PLL] && !ref_e
        |=> q.st == CSM_WAIT)
        else $error("left wait without PLL lock");
    commit_point_a: assert property (@(posedge clk) disable iff (!rstn)
        q.st == CSM_SETTLE && new_e && q.settle == 4'h9
        |=> (q.cur == $past(q.req_src) && !q.req) || q.trap)
        else $error("switch not committed on tenth edge");
    ref_osc_on_a: assert property (@(posedge clk) disable iff (!rstn)
        sw_en |=> q.osc_en[CSM_OSC_LOW_POWER_RC_OSCILLATOR])
        else $error("low-power RC off while monitor enabled");
    trap_fallback_a: assert property (@(posedge clk) disable iff (!rstn)
        q.trap |-> q.cf && (q.cur == CSM_SRC_FRC || q.cur == CSM_SRC_FRC_PLL))
        else $error("trap without fast RC fallback");
    locked_write_a: assert property (@(posedge clk) disable iff (!rstn)
        bus.wr && q.key != CSM_KEY_OPEN && q.cfg_done |=> $stable(q.req_src))
        else $error("locked write changed requested source");

    commit_clears_a: assert property (@(posedge clk) disable iff (!rstn)
        q.st == CSM_SETTLE ##1 q.st == CSM_IDLE |-> !q.req)
        else $error("request bit still set after switch");

    old_src_off_a: assert property (@(posedge clk) disable iff (!rstn)
        q.st == CSM_IDLE && !q.keep_lp && q.cur != CSM_SRC_LP |-> !q.osc_en[CSM_OSC_LP])
        else $error("old low-power crystal left running");

    keep_lp_on_a: assert property (@(posedge clk) disable iff (!rstn)
        q.keep_lp |-> q.osc_en[CSM_OSC_LP])
        else $error("low-power crystal off while keep-on set");

    tune_write_a: assert property (@(posedge clk) disable iff (!rstn)
        bus.wr && bus.addr == CSM_ADDR_TUNE |=> tuning_step_field == $past(bus.wdata[5:0]))
        else $error("tuning write not applied");

    tune_read_a: assert property (@(posedge clk) disable iff (!rstn)
        bus.rd && bus.addr == CSM_ADDR_TUNE |=> rd_data == {10'h000, $past(q.tune)})
        else $error("tuning read returned wrong data");

    read_idle_a: assert property (@(posedge clk) disable iff (!rstn)
        !bus.rd |=> rd_data == 16'h0000)
        else $error("read data present without a read");

    pll_fallback_a: assert property (@(posedge clk) disable iff (!rstn)
        q.trap && ($past(q.cur) == CSM_SRC_PRI_PLL || $past(q.cur) == CSM_SRC_FRC_PLL)
        |-> q.cur == CSM_SRC_FRC_PLL)
        else $error("fallback dropped the PLL");

    no_trap_off_a: assert property (@(posedge clk) disable iff (!rstn)
        q.cfg_done && q.cfg.switching_enable_config |-> !q.trap)
        else $error("trap raised while monitor disabled");

    ost_wait_a: assert property (@(posedge clk) disable iff (!rstn)
        q.st == CSM_WAIT && q.req_src == CSM_SRC_LP && !q.sync2[CSM_IN_OST] && !ref_e
        |=> q.st == CSM_WAIT)
        else $error("left wait before start-up timer");

    switch_done_c: cover property (@(posedge clk) disable iff (!rstn)
        q.st == CSM_SETTLE ##1 q.st == CSM_IDLE);
    fail_trap_c: cover property (@(posedge clk) disable iff (!rstn) q.trap);
    redundant_c: cover property (@(posedge clk) disable iff (!rstn)
        q.st == CSM_IDLE && q.req && q.req_src == q.cur);
    // Switch onto a multiplied source
    pll_switch_c: cover property (@(posedge clk) disable iff (!rstn)
        q.st == CSM_WAIT && uses_pll(q.req_src) ##1 q.st == CSM_SETTLE);
    // Fallback keeping the PLL
    pll_trap_c: cover property (@(posedge clk) disable iff (!rstn)
        q.trap && q.cur == CSM_SRC_FRC_PLL);
endmodule
`default_nettype wire

// ===== verilog/csm_pkg.sv
// Constants, types and register map of the clock switch and fail-safe monitor
package csm_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] CSM_ADDR_CTRL_HI = 4'h0;
    localparam logic [3:0] CSM_ADDR_CTRL_LO = 4'h1;
    localparam logic [3:0] CSM_ADDR_TUNE = 4'h2;
    localparam logic [3:0] CSM_ADDR_KEY = 4'h3;
    // Field positions in oscillator_control_register
    localparam int CSM_CUR_LSB = 12;
    localparam int CSM_REQ_LSB = 8;
    localparam int CSM_LOCK_BIT = 5;
    localparam int CSM_CF_BIT = 3;
    localparam int CSM_KEEP_BIT = 1;
    localparam int CSM_SW_BIT = 0;
    localparam logic [15:0] CSM_TUNE_RESET = 16'h0000;
    // Unlock keys, values arbitrary
    localparam logic [15:0] CSM_KEY1 = 16'h5a5a;
    localparam logic [15:0] CSM_KEY2 = 16'ha5a5;
    // New-clock edges before commit, reference edges without a system edge
    localparam logic [3:0] CSM_SETTLE_EDGES = 4'ha;
    localparam logic [3:0] CSM_FAIL_EDGES = 4'h8;
    // Index of each synchronised input
    localparam int CSM_IN_NEW = 0;
    localparam int CSM_IN_MON = 1;
    localparam int CSM_IN_REF = 2;
    localparam int CSM_IN_OST = 3;
    localparam int CSM_IN_PLL = 4;
    // Index of each oscillator enable
    localparam int CSM_OSC_PRI = 0;
    localparam int CSM_OSC_LP = 1;
    localparam int CSM_OSC_FRC = 2;
    localparam int CSM_OSC_LOW_POWER_RC_OSCILLATOR = 3;
    localparam int CSM_OSC_PLL = 4;

    typedef enum logic [2:0] {
        CSM_SRC_FRC = 3'h0,
        CSM_SRC_FRC_PLL = 3'h1,
        CSM_SRC_PRI = 3'h2,
        CSM_SRC_PRI_PLL = 3'h3,
        CSM_SRC_LP = 3'h4,
        CSM_SRC_LOW_POWER_RC_OSCILLATOR = 3'h5
    } csm_src_t;

    typedef enum logic [2:0] {
        CSM_IDLE = 3'b001,
        CSM_WAIT = 3'b010,
        CSM_SETTLE = 3'b100
    } csm_state_t;

    localparam logic [1:0] CSM_SUB_EC = 2'h0;
    localparam logic [1:0] CSM_KEY_NONE = 2'h0;
    localparam logic [1:0] CSM_KEY_HALF = 2'h1;
    localparam logic [1:0] CSM_KEY_OPEN = 2'h2;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } csm_bus_t;

    typedef struct packed {
        logic switching_enable_config;
        logic [2:0] initial_source_config;
        logic [1:0] primary_submode_select;
        logic watchdog_en;
    } csm_cfg_t;
endpackage
